// file: fcpe_host_ctrl.sv
/*
 * Host-side controller that drives a boot-block flash through its parallel pins:
 * block erase, status polling, suspend/resume, read-array, array reads, clear status.
 * Assumes flash pins sampled synchronously to sys_clk_i and software on a plain register port.
 */
// Decided for this implementation: the strobed register port and the address map.
// How it works
// - erase is setup code 20h, then D0h with block bits on A12-A17
// - every status poll read gets its own chip or output enable pulse
// - bit 3 flags low program voltage, bit 4 program failure; host checks them
// - after any error flag, clear status before the next program or erase
// - suspend code B0h during erase; flash then returns status on reads
// - while suspended, read-array then read only blocks other than the erased one
// - confirm code D0h while suspended resumes the erase
// - boot block changes only with unlock voltage on the reset pin or write-protect high
`timescale 1ns/1ps
module fcpe_host_ctrl (
	input wire logic sys_clk_i, // 20 MHz clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic [fcpe_pkg::SW_AW-1:0] sw_addr_i, // register byte address
	input wire logic [fcpe_pkg::SW_DW-1:0] sw_wdata_i, // write data
	input wire logic sw_we_i, // write strobe
	input wire logic sw_re_i, // read strobe
	output logic [fcpe_pkg::SW_DW-1:0] sw_rdata_o, // read data, cycle after strobe
	output logic irq_o, // level interrupt
	output logic [fcpe_pkg::FLASH_AW-1:0] flash_addr_o, // flash address
	output logic [fcpe_pkg::FLASH_DW-1:0] flash_dq_o, // flash data out
	output logic flash_dq_oe_o, // flash data drive enable
	input wire logic [fcpe_pkg::FLASH_DW-1:0] flash_dq_i, // flash data in
	output logic flash_ce_b_o, // chip enable, low active
	output logic flash_oe_b_o, // output enable, low active
	output logic flash_we_b_o, // write enable, low active
	output logic reset_powerdown_unlock_pin_vhh_o, // request unlock high voltage
	output logic flash_wp_o // write protect pin level
);
	import fcpe_pkg::*;

	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	fcpe_state_t state_reg, state_next;
	fcpe_job_t job_reg, job_next, sw_cmd;
	fcpe_phase_t phase_reg, phase_next;
	fcpe_acc_t acc_reg, acc_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [BLK_W-1:0] blk_reg, blk_next, blk_sel;
	logic [FLASH_AW-1:0] addr_reg, addr_next;
	logic [FLASH_DW-1:0] lat_reg, lat_next, fstat_reg, fstat_next, rd_reg, rd_next;
	logic susp_req_reg, susp_req_next, susp_reg, susp_next;
	logic errp_reg, errp_next, array_reg, array_next, unl_reg, unl_next;
	logic [EVT_W-1:0] istat_reg, istat_next, ien_reg, ien_next, evt;
	logic ce_b_next, oe_b_next, we_b_next, dq_oe_next, irq_next;
	logic [SW_DW-1:0] rdata_next;
	logic start_ok, busy, err_now;

	function automatic fcpe_acc_t acc_for(input fcpe_job_t job, input fcpe_phase_t ph,
			input logic [BLK_W-1:0] blk, input logic [FLASH_AW-1:0] adr);
		fcpe_acc_t a;
		a.wr = 1'b1;
		a.data = CODE_READ_ARRAY;
		a.addr = {blk, BLK_OFS_ZERO};
		if (ph == PH_POLL) begin
			a.wr = 1'b0; // a fresh read each time the poll loops
		end else begin
			case (job)
				JOB_ERASE: a.data = (ph == PH_FIRST) ? CODE_ERASE_SETUP : CODE_CONFIRM;
				JOB_RESUME: a.data = CODE_CONFIRM;
				JOB_SUSPEND: a.data = CODE_SUSPEND;
				JOB_CLEAR: a.data = CODE_CLEAR_STATUS;
				JOB_READ: begin
					a.wr = 1'b0;
					a.addr = adr;
				end
				default: a.data = CODE_READ_ARRAY;
			endcase
		end
		return a;
	endfunction : acc_for

	always_comb begin
		state_next = state_reg;
		job_next = job_reg;
		phase_next = phase_reg;
		acc_next = acc_reg;
		cnt_next = cnt_reg;
		blk_next = blk_reg;
		addr_next = addr_reg;
		lat_next = lat_reg;
		fstat_next = fstat_reg;
		rd_next = rd_reg;
		susp_req_next = susp_req_reg;
		susp_next = susp_reg;
		errp_next = errp_reg;
		array_next = array_reg;
		unl_next = unl_reg;
		ien_next = ien_reg;
		evt = '0;
		start_ok = 1'b0;
		busy = (state_reg != S_IDLE);
		sw_cmd = fcpe_job_t'(sw_wdata_i[2:0]);
		blk_sel = (sw_cmd == JOB_ERASE) ? addr_reg[FLASH_AW-1:BLK_LO] : blk_reg;
		err_now = lat_reg[FST_VPP_LOW] | lat_reg[FST_PROG_ERR] | lat_reg[FST_ERASE_ERR];

		if (sw_we_i && sw_addr_i == REG_ADDR) begin
			addr_next = sw_wdata_i[FLASH_AW-1:0];
		end
		if (sw_we_i && sw_addr_i == REG_IRQ_EN) begin
			ien_next = sw_wdata_i[EVT_W-1:0];
		end
		if (sw_we_i && sw_addr_i == REG_CMD) begin
			unique case (sw_cmd)
				JOB_SUSPEND: begin
					// only accepted while an erase or resume job is busy; acted on at a not-ready poll
					if (busy && (job_reg == JOB_ERASE || job_reg == JOB_RESUME)) begin
						susp_req_next = 1'b1;
					end else begin
						evt[EVT_REFUSED] = 1'b1;
					end
				end
				JOB_ERASE: start_ok = !busy && !errp_reg && !susp_reg;
				JOB_RESUME: start_ok = !busy && susp_reg;
				JOB_RDARR: start_ok = !busy;
				JOB_READ: start_ok = !busy && array_reg &&
						!(susp_reg && addr_reg[FLASH_AW-1:BLK_LO] == blk_reg);
				JOB_CLEAR: start_ok = !busy && !susp_reg;
				default: start_ok = 1'b0;
			endcase
			if (sw_cmd != JOB_SUSPEND && !start_ok) begin
				evt[EVT_REFUSED] = 1'b1;
			end
		end
		if (start_ok) begin
			job_next = sw_cmd;
			phase_next = PH_FIRST;
			state_next = S_SETUP;
			blk_next = blk_sel;
			acc_next = acc_for(sw_cmd, PH_FIRST, blk_sel, addr_reg);
			cnt_next = SET_LOAD;
			if (sw_cmd != JOB_READ) begin
				array_next = (sw_cmd == JOB_RDARR);
			end
			if (sw_cmd == JOB_RESUME) begin
				susp_next = 1'b0;
			end
			if ((sw_cmd == JOB_ERASE || sw_cmd == JOB_RESUME) && blk_sel == BOOT_BLK) begin
				unl_next = 1'b1;
				cnt_next = UNL_LOAD; // unlock voltage must settle before the strobe
			end
		end

		unique case (state_reg)
			S_IDLE: ;
			S_SETUP: begin
				if (cnt_reg == CNT_ZERO) begin
					state_next = S_PULSE;
					cnt_next = acc_reg.wr ? WE_LOAD : RD_LOAD;
				end else begin
					cnt_next = cnt_reg - CNT_ONE;
				end
			end
			S_PULSE: begin
				if (cnt_reg == CNT_ZERO) begin
					state_next = S_GAP;
					cnt_next = GAP_LOAD;
					if (!acc_reg.wr) begin
						lat_next = flash_dq_i;
					end
				end else begin
					cnt_next = cnt_reg - CNT_ONE;
				end
			end
			S_GAP: begin
				if (cnt_reg == CNT_ZERO) begin
					state_next = S_DECIDE;
				end else begin
					cnt_next = cnt_reg - CNT_ONE;
				end
			end
			S_DECIDE: begin
				state_next = S_SETUP;
				cnt_next = SET_LOAD;
				if (phase_reg == PH_FIRST && job_reg == JOB_ERASE) begin
					phase_next = PH_SECOND;
				end else if (phase_reg != PH_POLL &&
						(job_reg == JOB_ERASE || job_reg == JOB_RESUME || job_reg == JOB_SUSPEND)) begin
					phase_next = PH_POLL;
				end else if (phase_reg == PH_POLL && !lat_reg[FST_READY]) begin
					fstat_next = lat_reg;
					if (susp_req_reg && job_reg != JOB_SUSPEND) begin
						job_next = JOB_SUSPEND;
						phase_next = PH_FIRST;
						susp_req_next = 1'b0;
					end
				end else begin
					state_next = S_IDLE;
					job_next = JOB_NONE;
					evt[EVT_DONE] = 1'b1;
					susp_req_next = 1'b0;
					if (phase_reg == PH_POLL) begin
						fstat_next = lat_reg;
						if (job_reg == JOB_SUSPEND && lat_reg[FST_SUSPENDED]) begin
							susp_next = 1'b1;
							evt[EVT_SUSP] = 1'b1;
						end else begin
							// erase has ended: drop unlock so the boot block relocks
							unl_next = 1'b0;
							errp_next = errp_reg | err_now;
							evt[EVT_ERR] = err_now;
						end
					end
					unique case (job_reg)
						JOB_READ: rd_next = lat_reg;
						JOB_CLEAR: errp_next = 1'b0;
						default: ;
					endcase
				end
				acc_next = acc_for(job_next, phase_next, blk_reg, addr_reg);
			end
			default: state_next = S_IDLE;
		endcase

		// a fresh event wins over a clear in the same cycle
		istat_next = istat_reg;
		if (sw_we_i && sw_addr_i == REG_IRQ_CLR) begin
			istat_next = istat_reg & ~sw_wdata_i[EVT_W-1:0];
		end
		istat_next = istat_next | evt;
		irq_next = |(istat_next & ien_next);

		ce_b_next = !(state_next == S_SETUP || state_next == S_PULSE);
		we_b_next = !(state_next == S_PULSE && acc_next.wr);
		oe_b_next = !(state_next == S_PULSE && !acc_next.wr);
		dq_oe_next = acc_next.wr && (state_next == S_SETUP || state_next == S_PULSE ||
				state_next == S_GAP);

		rdata_next = '0;
		if (sw_re_i) begin
			unique case (sw_addr_i)
				REG_STATUS: begin
					rdata_next[ST_BUSY] = busy;
					rdata_next[ST_SUSP] = susp_reg;
					rdata_next[ST_ERRP] = errp_reg;
					rdata_next[ST_ARRAY] = array_reg;
					rdata_next[ST_FLASH_LO +: FLASH_DW] = fstat_reg;
				end
				REG_DATA: rdata_next[FLASH_DW-1:0] = rd_reg;
				REG_IRQ_STAT: rdata_next[EVT_W-1:0] = istat_reg;
				REG_IRQ_EN: rdata_next[EVT_W-1:0] = ien_reg;
				REG_ADDR: rdata_next[FLASH_AW-1:0] = addr_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			job_reg <= JOB_NONE;
			phase_reg <= PH_FIRST;
			acc_reg <= '0;
			cnt_reg <= CNT_ZERO;
			blk_reg <= BOOT_BLK;
			addr_reg <= '0;
			lat_reg <= '0;
			fstat_reg <= '0;
			rd_reg <= '0;
			susp_req_reg <= 1'b0;
			susp_reg <= 1'b0;
			errp_reg <= 1'b0;
			array_reg <= 1'b1;
			unl_reg <= 1'b0;
			istat_reg <= '0;
			ien_reg <= '0;
			irq_o <= 1'b0;
			sw_rdata_o <= '0;
			flash_ce_b_o <= 1'b1;
			flash_oe_b_o <= 1'b1;
			flash_we_b_o <= 1'b1;
			flash_dq_oe_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			job_reg <= job_next;
			phase_reg <= phase_next;
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
			blk_reg <= blk_next;
			addr_reg <= addr_next;
			lat_reg <= lat_next;
			fstat_reg <= fstat_next;
			rd_reg <= rd_next;
			susp_req_reg <= susp_req_next;
			susp_reg <= susp_next;
			errp_reg <= errp_next;
			array_reg <= array_next;
			unl_reg <= unl_next;
			istat_reg <= istat_next;
			ien_reg <= ien_next;
			irq_o <= irq_next;
			sw_rdata_o <= rdata_next;
			flash_ce_b_o <= ce_b_next;
			flash_oe_b_o <= oe_b_next;
			flash_we_b_o <= we_b_next;
			flash_dq_oe_o <= dq_oe_next;
		end
	end
	assign flash_addr_o = acc_reg.addr;
	assign flash_dq_o = acc_reg.data;
	assign reset_powerdown_unlock_pin_vhh_o = unl_reg;
	assign flash_wp_o = unl_reg;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);
	AST_CONFIRM_CARRIES_BLOCK: assert property (
		$fell(flash_we_b_o) && job_reg == JOB_ERASE && flash_dq_o == CODE_CONFIRM
		|-> flash_addr_o[FLASH_AW-1:BLK_LO] == blk_reg && $past(flash_dq_o, 6) == CODE_ERASE_SETUP)
		else $error("erase confirm without block address");
	AST_OE_TOGGLES: assert property ($fell(flash_oe_b_o) |-> ##3 flash_oe_b_o)
		else $error("output enable not released after a read");
	AST_POLL_UNTIL_READY: assert property (
		state_reg == S_DECIDE && phase_reg == PH_POLL && !lat_reg[FST_READY] |=> state_reg == S_SETUP)
		else $error("poll loop left before ready");
	AST_ERROR_STICKS: assert property (
		state_reg == S_DECIDE && phase_reg == PH_POLL && lat_reg[FST_READY] && job_reg == JOB_ERASE
		&& err_now |=> errp_reg && istat_reg[EVT_ERR])
		else $error("flash error flag not recorded");
	AST_CLEAR_BEFORE_ERASE: assert property (
		sw_we_i && sw_addr_i == REG_CMD && sw_cmd == JOB_ERASE && errp_reg
		|=> state_reg == S_IDLE && istat_reg[EVT_REFUSED])
		else $error("erase started with an uncleared error");
	AST_SUSPEND_CODE: assert property (
		$fell(flash_we_b_o) && job_reg == JOB_SUSPEND |-> flash_dq_o == CODE_SUSPEND)
		else $error("suspend written with a wrong code");
	AST_RESUME_NEEDS_SUSPEND: assert property (
		sw_we_i && sw_addr_i == REG_CMD && sw_cmd == JOB_RESUME && !susp_reg && !busy
		|=> job_reg == JOB_NONE ##1 flash_we_b_o)
		else $error("resume issued without a suspended erase");
	AST_READ_OTHER_BLOCK: assert property (
		$fell(flash_oe_b_o) && job_reg == JOB_READ && susp_reg
		|-> flash_addr_o[FLASH_AW-1:BLK_LO] != blk_reg)
		else $error("read of the suspended block");
	AST_BOOT_UNLOCKED: assert property (
		$fell(flash_we_b_o) && blk_reg == BOOT_BLK && (job_reg == JOB_ERASE || job_reg == JOB_RESUME)
		|-> reset_powerdown_unlock_pin_vhh_o && flash_wp_o)
		else $error("boot block written while locked");
	COV_ERASE_DONE: cover property (state_reg == S_DECIDE && job_reg == JOB_ERASE && lat_reg[FST_READY]);
	COV_SUSPENDED: cover property ($rose(susp_reg));
	COV_RESUMED: cover property (job_reg == JOB_RESUME && $fell(flash_we_b_o));
	COV_REFUSED: cover property ($rose(istat_reg[EVT_REFUSED]));
endmodule : fcpe_host_ctrl

// file: fcpe_pkg.sv
/*
 * Constants, codes, register map and types for the flash erase sequencer host.
 * Assumes a 20 MHz system clock and an x8 boot-block flash with synchronous-sampled pins.
 */
package fcpe_pkg;
	// clock and flash pin timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_WE_PULSE_NS = 70;
	localparam int T_READ_ACCESS_NS = 120;
	localparam int T_RECOVERY_NS = 40;
	localparam int T_UNLOCK_SETUP_NS = 100;
	localparam int T_ADDR_SETUP_NS = 50;
	// least times round up, never below one cycle
	localparam int WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNL_CYC = (T_UNLOCK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SET_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 2;
	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
	localparam logic [CNT_W-1:0] WE_LOAD = CNT_W'(WE_CYC - 1);
	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] UNL_LOAD = CNT_W'(UNL_CYC - 1);
	localparam logic [CNT_W-1:0] SET_LOAD = CNT_W'(SET_CYC - 1);
	// flash geometry
	localparam int FLASH_AW = 18;
	localparam int FLASH_DW = 8;
	localparam int BLK_LO = 12;
	localparam int BLK_W = FLASH_AW - BLK_LO;
	localparam logic [BLK_W-1:0] BOOT_BLK = 6'h00;
	localparam logic [BLK_LO-1:0] BLK_OFS_ZERO = 12'h000;
	// flash command codes; the clear-status code is a plain default
	localparam logic [FLASH_DW-1:0] CODE_ERASE_SETUP = 8'h20;
	localparam logic [FLASH_DW-1:0] CODE_CONFIRM = 8'hD0;
	localparam logic [FLASH_DW-1:0] CODE_SUSPEND = 8'hB0;
	localparam logic [FLASH_DW-1:0] CODE_READ_ARRAY = 8'hFF;
	localparam logic [FLASH_DW-1:0] CODE_CLEAR_STATUS = 8'h50;
	// flash status bits
	localparam int FST_VPP_LOW = 3;
	localparam int FST_PROG_ERR = 4;
	localparam int FST_ERASE_ERR = 5;
	localparam int FST_SUSPENDED = 6;
	localparam int FST_READY = 7;
	// software register map
	localparam int SW_AW = 5;
	localparam int SW_DW = 32;
	localparam logic [SW_AW-1:0] REG_CMD = 5'h00;
	localparam logic [SW_AW-1:0] REG_ADDR = 5'h04;
	localparam logic [SW_AW-1:0] REG_STATUS = 5'h08;
	localparam logic [SW_AW-1:0] REG_DATA = 5'h0C;
	localparam logic [SW_AW-1:0] REG_IRQ_STAT = 5'h10;
	localparam logic [SW_AW-1:0] REG_IRQ_CLR = 5'h14;
	localparam logic [SW_AW-1:0] REG_IRQ_EN = 5'h18;
	localparam int ST_BUSY = 0;
	localparam int ST_SUSP = 1;
	localparam int ST_ERRP = 2;
	localparam int ST_ARRAY = 3;
	localparam int ST_FLASH_LO = 8;
	localparam int EVT_W = 4;
	localparam int EVT_DONE = 0;
	localparam int EVT_ERR = 1;
	localparam int EVT_REFUSED = 2;
	localparam int EVT_SUSP = 3;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_SETUP = 3'h1, S_PULSE = 3'h3, S_GAP = 3'h2, S_DECIDE = 3'h6
	} fcpe_state_t;
	typedef enum logic [2:0] {
		JOB_NONE = 3'h0, JOB_ERASE = 3'h1, JOB_SUSPEND = 3'h2, JOB_RESUME = 3'h3,
		JOB_RDARR = 3'h4, JOB_READ = 3'h5, JOB_CLEAR = 3'h6
	} fcpe_job_t;
	typedef enum logic [1:0] {PH_FIRST = 2'h0, PH_SECOND = 2'h1, PH_POLL = 2'h3} fcpe_phase_t;
	typedef struct packed {
		logic wr;
		logic [FLASH_DW-1:0] data;
		logic [FLASH_AW-1:0] addr;
	} fcpe_acc_t;
endpackage : fcpe_pkg

// file: fcpe_flash_model.sv
/*
 * Behavioural x8 boot-block flash: command interface, status byte, timed erase, suspend.
 * Assumes pins driven by a host synchronous to clk_i; array content is never programmed.
 */
`timescale 1ns/1ps
module fcpe_flash_model
	import fcpe_pkg::*;
#(
	parameter int ERASE_CYC = 60
) (
	input wire logic clk_i, // sampling clock
	input wire logic [FLASH_AW-1:0] addr_i, // address pins
	input wire logic [FLASH_DW-1:0] dq_i, // data from host
	input wire logic ce_b_i, // chip enable, low active
	input wire logic oe_b_i, // output enable, low active
	input wire logic we_b_i, // write enable, low active
	input wire logic vhh_i, // unlock voltage on reset pin
	input wire logic wp_i, // write protect level
	input wire logic [1:0] fault_i, // 1 erase fail, 2 low vpp, 3 sequence error
	output logic [FLASH_DW-1:0] dq_o, // data to host
	output logic [BLK_W-1:0] erase_blk_o, // block of last confirmed erase
	output logic boot_viol_o // boot erase seen while locked
);
	import fcpe_pkg::*;
	logic [7:0] sr = 8'h80;
	logic stat = 1'b0;
	logic setup = 1'b0;
	logic susp_req = 1'b0;
	logic we_q = 1'b1;
	logic [7:0] last_q = 8'h00;
	int busy_cnt = 0;
	initial erase_blk_o = 6'h3F;
	initial boot_viol_o = 1'b0;
	// released bus shows inverse of last value so a stale sample cannot pass
	assign dq_o = (!ce_b_i && !oe_b_i) ? (stat ? sr : 8'hFF) : ~last_q;
	always @(posedge clk_i) begin
		we_q <= we_b_i;
		if (!ce_b_i && !oe_b_i) last_q <= dq_o;
		if (busy_cnt > 0 && !sr[6]) begin
			if (susp_req) begin
				sr[7] <= 1'b1;
				sr[6] <= 1'b1;
				susp_req <= 1'b0;
			end else begin
				busy_cnt <= busy_cnt - 1;
				if (busy_cnt == 1) begin
					sr[7] <= 1'b1;
					susp_req <= 1'b0;
					case (fault_i)
						2'h1: sr[5] <= 1'b1;
						2'h2: sr[3] <= 1'b1;
						2'h3: sr[5:4] <= 2'h3;
						default: ;
					endcase
				end
			end
		end
		// commands only take effect on a write strobe edge; the erase countdown above runs every cycle the erase is not suspended
		if (!we_b_i && we_q && !ce_b_i) begin
			if (setup) begin
				setup <= 1'b0;
				if (dq_i == 8'hD0) begin
					erase_blk_o <= addr_i[FLASH_AW-1:BLK_LO];
					busy_cnt <= ERASE_CYC;
					sr[7] <= 1'b0;
					if (addr_i[FLASH_AW-1:BLK_LO] == 6'h00 && !vhh_i && !wp_i) begin
						boot_viol_o <= 1'b1;
					end
				end else begin
					sr[5:4] <= 2'h3;
				end
			end else if (sr[6]) begin
				if (dq_i == 8'hFF) stat <= 1'b0;
				else if (dq_i == 8'hD0) begin
					sr[6] <= 1'b0;
					sr[7] <= 1'b0;
					stat <= 1'b1;
				end
			end else begin
				case (dq_i)
					8'h20: begin
						setup <= 1'b1;
						stat <= 1'b1;
					end
					8'hB0: begin
						if (!sr[7]) susp_req <= 1'b1;
						stat <= 1'b1;
					end
					8'hFF: stat <= 1'b0;
					8'h50: sr[5:3] <= 3'h0;
					default: ;
				endcase
			end
		end
	end
endmodule : fcpe_flash_model

// file: fcpe_host_ctrl_tb.sv
/*
 * Self-checking bench for the flash erase host: register tasks, erase, faults, suspend, boot.
 * Assumes the flash model beside it and the design's package constants.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module fcpe_host_ctrl_tb;
	import fcpe_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [SW_AW-1:0] sw_addr = '0;
	logic [SW_DW-1:0] sw_wdata = '0;
	logic sw_we = 1'b0;
	logic sw_re = 1'b0;
	logic [SW_DW-1:0] sw_rdata;
	logic irq, dq_oe, ce_b, oe_b, we_b, unlock_high_voltage, wp, boot_viol;
	logic [FLASH_AW-1:0] f_addr;
	logic [FLASH_DW-1:0] f_dq_o, f_dq_i;
	logic [BLK_W-1:0] blk_seen;
	logic [1:0] fault = 2'h0;
	logic [7:0] fmask [1:3] = '{8'h20, 8'h08, 8'h30};
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #25 sys_clk = ~sys_clk;
	fcpe_host_ctrl dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .sw_addr_i(sw_addr),
		.sw_wdata_i(sw_wdata), .sw_we_i(sw_we), .sw_re_i(sw_re), .sw_rdata_o(sw_rdata),
		.irq_o(irq), .flash_addr_o(f_addr), .flash_dq_o(f_dq_o), .flash_dq_oe_o(dq_oe),
		.flash_dq_i(f_dq_i), .flash_ce_b_o(ce_b), .flash_oe_b_o(oe_b), .flash_we_b_o(we_b),
		.reset_powerdown_unlock_pin_vhh_o(unlock_high_voltage), .flash_wp_o(wp));
	fcpe_flash_model flash (.clk_i(sys_clk), .addr_i(f_addr), .dq_i(f_dq_o), .ce_b_i(ce_b),
		.oe_b_i(oe_b), .we_b_i(we_b), .vhh_i(unlock_high_voltage), .wp_i(wp), .fault_i(fault),
		.dq_o(f_dq_i), .erase_blk_o(blk_seen), .boot_viol_o(boot_viol));
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	// data pins must be driven for every write pulse and released for every read
	always @(negedge sys_clk) begin
		if (!we_b) `CHK(dq_oe, 1'b1)
		if (!oe_b) `CHK(dq_oe, 1'b0)
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			$display("unexpected at %0t: run too long", $time);
			close_out();
		end
	end
	task automatic wr(input logic [SW_AW-1:0] a, input logic [SW_DW-1:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_we <= 1'b1;
		@(posedge sys_clk);
		sw_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [SW_AW-1:0] a, output logic [SW_DW-1:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_re <= 1'b1;
		@(posedge sys_clk);
		sw_re <= 1'b0;
		#1 d = sw_rdata;
	endtask : rd
	task automatic ckr(input logic [SW_AW-1:0] a, input logic [SW_DW-1:0] m, e);
		logic [SW_DW-1:0] v;
		rd(a, v);
		`CHK(v & m, e)
	endtask : ckr
	// bounded poll of the busy flag
	task automatic idle;
		logic [SW_DW-1:0] s;
		int n;
		n = 0;
		do begin
			rd(REG_STATUS, s);
			n++;
		end while (s[ST_BUSY] !== 1'b0 && n < 400);
		if (n >= 400) begin
			errors++;
			$display("unexpected at %0t: job never finished", $time);
		end
	endtask : idle
	task automatic refused;
		ckr(REG_IRQ_STAT, 32'h4, 32'h4);
		wr(REG_IRQ_CLR, 32'hF);
	endtask : refused
	task automatic tdone(input string s);
		$display("test %s done, mismatches %0d", s, errors);
	endtask : tdone
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		ckr(REG_STATUS, 32'hF, 32'h8);
		ckr(5'h1C, '1, 32'h0);
		tdone("reset");
		wr(REG_ADDR, 32'h5000);
		ckr(REG_ADDR, '1, 32'h5000);
		wr(REG_CMD, 32'h1);
		idle();
		ckr(REG_STATUS, 32'hFF05, 32'h8000);
		`CHK(blk_seen, 6'h05)
		`CHK(irq, 1'b0)
		ckr(REG_IRQ_STAT, 32'h1, 32'h1);
		wr(REG_IRQ_EN, 32'h1);
		repeat (2) @(posedge sys_clk);
		#1 `CHK(irq, 1'b1)
		ckr(REG_IRQ_EN, '1, 32'h1);
		wr(REG_IRQ_CLR, 32'hF);
		repeat (2) @(posedge sys_clk);
		#1 `CHK(irq, 1'b0)
		tdone("erase");
		for (int i = 1; i <= 3; i++) begin
			fault <= 2'(i);
			wr(REG_ADDR, 32'h2000);
			wr(REG_CMD, 32'h1);
			idle();
			fault <= 2'h0;
			ckr(REG_STATUS, 32'h3804, {16'h0, fmask[i] & 8'h38, 8'h4});
			wr(REG_IRQ_CLR, 32'hF);
			wr(REG_CMD, 32'h1);
			refused();
			ckr(REG_STATUS, 32'h4, 32'h4);
			wr(REG_CMD, 32'h6);
			idle();
			// status mirror keeps the last polled byte; only the pending flag drops
			ckr(REG_STATUS, 32'h3804, {16'h0, fmask[i] & 8'h38, 8'h0});
			wr(REG_IRQ_CLR, 32'hF);
		end
		tdone("faults");
		wr(REG_ADDR, 32'h3000);
		wr(REG_CMD, 32'h1);
		repeat (20) @(posedge sys_clk);
		wr(REG_CMD, 32'h2);
		idle();
		ckr(REG_STATUS, 32'hC002, 32'hC002);
		wr(REG_IRQ_CLR, 32'hF);
		wr(REG_CMD, 32'h6);
		refused();
		wr(REG_CMD, 32'h4);
		idle();
		wr(REG_ADDR, 32'h7000);
		wr(REG_CMD, 32'h5);
		idle();
		ckr(REG_DATA, 32'hFF, 32'hFF);
		wr(REG_ADDR, 32'h3000);
		wr(REG_CMD, 32'h5);
		refused();
		wr(REG_CMD, 32'h3);
		idle();
		ckr(REG_STATUS, 32'hC002, 32'h8000);
		wr(REG_IRQ_CLR, 32'hF);
		tdone("suspend");
		wr(REG_CMD, 32'h3);
		refused();
		wr(REG_CMD, 32'h4);
		idle();
		ckr(REG_STATUS, 32'h8, 32'h8);
		wr(REG_CMD, 32'h2);
		refused();
		wr(REG_CMD, 32'h7);
		refused();
		tdone("resume idle");
		wr(REG_ADDR, 32'h0);
		wr(REG_CMD, 32'h1);
		idle();
		`CHK(blk_seen, 6'h00)
		`CHK(boot_viol, 1'b0)
		`CHK({unlock_high_voltage, wp}, 2'h0)
		ckr(REG_STATUS, 32'hFF05, 32'h8000);
		tdone("boot");
		close_out();
	end
endmodule : fcpe_host_ctrl_tb
